// [logic/ofs_pkg.sv]
// Package of constants for the output fault status report block.
`default_nettype none
package ofs_pkg;
  // ==========================================================================
  // Sizes
  localparam int unsigned OUT_BYTES = 2;
  localparam int unsigned OUT_BITS  = 16;
  localparam int unsigned GRP_W     = 5;
  localparam int unsigned PATH_W    = 4;
  localparam int unsigned ADDR_W    = 8;
  localparam int unsigned SW_W      = 16;
  // ==========================================================================
  // Register offsets
  localparam logic [7:0] OFS_FAULT0   = 8'h00;
  localparam logic [7:0] OFS_FAULT1   = 8'h04;
  localparam logic [7:0] OFS_STATUS   = 8'h08;
  localparam logic [7:0] OFS_MASK     = 8'h0C;
  localparam logic [7:0] OFS_GROUP    = 8'h10;
  localparam logic [7:0] OFS_PATH     = 8'h14;
  localparam logic [7:0] OFS_START    = 8'h18;
  localparam logic [7:0] OFS_OUTDATA  = 8'h1C;
  localparam logic [7:0] OFS_REPORT   = 8'h20;
  localparam logic [7:0] OFS_VARIANT  = 8'h24;
  // ==========================================================================
  // Reset values and limits
  localparam logic [4:0]  GROUP_MAX   = 5'h17;
  localparam logic [15:0] ZERO16      = 16'h0000;
  localparam logic [31:0] ZERO32      = 32'h0000_0000;
  // Variant capability words, top byte first: handwheels, inputs, outputs, safety inputs.
  localparam logic [31:0] CAP_REDUCED = 32'h0115_1003;
  localparam logic [31:0] CAP_FULL    = 32'h0318_1004;
endpackage
`default_nettype wire

// [logic/ofs_top.sv]
// Output fault detection and status reporting for a remote safety I/O unit.
// Operation
// RULE_01: Each output has protection; trip forces it off.
// RULE_02: Trip never raises unit alarm; location reported.
// RULE_03: Trip reported as status alarm to controller.
// RULE_04: Status bit k set when driver k faults.
// RULE_05: Alarm number 0 is start byte, 1 next.
// RULE_06: Group, path, address come from assignment registers.
// RULE_07: Group number limited to 0 through 23.
// RULE_08: Configurer maps module into two consecutive groups.
// RULE_09: Reduced variant: 4 in, 2 out, 2 safety.
// RULE_10: Full variant: 4 in, 2 out, 1 safety.
// RULE_11: Variant resources reported: inputs, outputs, safety, handwheels.
// RULE_12: Module attached only to enhanced link channels.
// RULE_13: Fault bit follows protection, clears on recovery.
//
// Implementation choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module ofs_top (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rstn,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // Output drivers and their protection sense
  input  wire logic [15:0] drv_overcur,
  input  wire logic [15:0] drv_overtemp,
  input  wire logic        variant_full,
  output logic      [15:0] out_drive,
  // Report to the ladder controller
  output logic             report_valid,
  output logic      [4:0]  report_group,
  output logic      [3:0]  report_path,
  output logic      [7:0]  report_addr,
  output logic      [7:0]  report_data,
  output logic             report_info,
  // Interrupt and unit alarm
  output logic             irq,
  output logic             unit_alarm
);
  // ==========================================================================
  // Protection and fault state
  logic [15:0] fault_r;
  logic [15:0] out_sw_r;
  logic [15:0] out_drive_r;
  logic [15:0] status_r;
  logic [15:0] mask_r;
  logic [4:0]  group_r;
  logic [3:0]  path_r;
  logic [7:0]  start_r;
  logic        irq_r;
  logic [31:0] rdata_r;
  logic        rpt_valid_r;
  logic [4:0]  rpt_group_r;
  logic [3:0]  rpt_path_r;
  logic [7:0]  rpt_addr_r;
  logic [7:0]  rpt_data_r;
  logic        rpt_info_r;
  logic [7:0]  rpt_seen_hi_r;
  logic        alarm_r;
  logic [15:0] fault_nxt;
  logic [15:0] rise;
  logic [15:0] status_nxt;
  logic        wr_status;
  logic [31:0] rdata_nxt;
  logic [4:0]  group_wr;
  logic        rpt_pending;
  logic        chg_lo;
  logic        chg_hi;
  logic        byte_sel;
  logic [15:0] clr_mask;
  logic [15:0] status_keep;
  // Live sense, no latching: the bit clears as soon as the driver recovers.
  assign fault_nxt = drv_overcur | drv_overtemp; // RULE_04 RULE_13
  assign rise      = fault_nxt & ~fault_r;
  assign wr_status = reg_wr && (reg_addr == ofs_pkg::OFS_STATUS);
  // Set wins over a write-one clear in the same cycle.
  assign clr_mask    = wr_status ? reg_wdata[15:0] : ofs_pkg::ZERO16;
  assign status_keep = status_r & ~clr_mask;
  assign status_nxt  = status_keep | rise;
  // Out-of-range group writes saturate at the top group.
  assign group_wr = (reg_wdata[4:0] > ofs_pkg::GROUP_MAX) ?
                    ofs_pkg::GROUP_MAX : reg_wdata[4:0]; // RULE_07
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      fault_r     <= ofs_pkg::ZERO16;
      out_drive_r <= ofs_pkg::ZERO16;
      status_r    <= ofs_pkg::ZERO16;
    end else begin
      fault_r     <= fault_nxt; // RULE_13
      out_drive_r <= out_sw_r & ~fault_nxt; // RULE_01
      status_r    <= status_nxt; // RULE_03
    end
  end
  // ==========================================================================
  // Configuration registers
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      out_sw_r <= ofs_pkg::ZERO16;
      mask_r   <= ofs_pkg::ZERO16;
      group_r  <= 5'h00;
      path_r   <= 4'h0;
      start_r  <= 8'h00;
    end else if (reg_wr) begin
      if (reg_addr == ofs_pkg::OFS_OUTDATA) out_sw_r <= reg_wdata[15:0];
      if (reg_addr == ofs_pkg::OFS_MASK)    mask_r   <= reg_wdata[15:0];
      if (reg_addr == ofs_pkg::OFS_GROUP)   group_r  <= group_wr; // RULE_06
      if (reg_addr == ofs_pkg::OFS_PATH)    path_r   <= reg_wdata[3:0]; // RULE_06
      if (reg_addr == ofs_pkg::OFS_START)   start_r  <= reg_wdata[7:0]; // RULE_06
    end
  end
  // ==========================================================================
  // Report to the ladder controller
  // A byte is reported whenever any of its fault bits changes. Byte 0 always
  // goes first; byte 1 is compared against what was last reported for it, so
  // a change there is never lost while byte 0 is busy. A byte 0 that changes
  // on every cycle holds byte 1 back for as long as it keeps changing.
  assign chg_lo      = |(fault_nxt[7:0] ^ fault_r[7:0]);
  assign chg_hi      = |(fault_nxt[15:8] ^ rpt_seen_hi_r);
  assign rpt_pending = chg_lo || chg_hi;
  assign byte_sel    = ~chg_lo;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rpt_valid_r <= 1'b0;
      rpt_group_r <= 5'h00;
      rpt_path_r  <= 4'h0;
      rpt_addr_r  <= 8'h00;
      rpt_data_r  <= 8'h00;
      rpt_info_r  <= 1'b0;
      rpt_seen_hi_r <= 8'h00;
    end else begin
      rpt_valid_r <= rpt_pending; // RULE_03
      if (rpt_pending) begin
        rpt_group_r <= group_r; // RULE_06
        rpt_path_r  <= path_r;
        rpt_info_r  <= byte_sel; // RULE_05
        rpt_addr_r  <= start_r + {7'h00, byte_sel}; // RULE_05
        rpt_data_r  <= byte_sel ? fault_nxt[15:8] : fault_nxt[7:0]; // RULE_04
        if (byte_sel) rpt_seen_hi_r <= fault_nxt[15:8]; // RULE_05
      end
    end
  end
  // ==========================================================================
  // Register read port and interrupt
  // Variant capability is static; the strap is sampled through the read path.
  always_comb begin
    rdata_nxt = ofs_pkg::ZERO32;
    unique case (reg_addr)
      ofs_pkg::OFS_FAULT0:  rdata_nxt = {24'h00_0000, fault_r[7:0]}; // RULE_05
      ofs_pkg::OFS_FAULT1:  rdata_nxt = {24'h00_0000, fault_r[15:8]}; // RULE_05
      ofs_pkg::OFS_STATUS:  rdata_nxt = {16'h0000, status_r};
      ofs_pkg::OFS_MASK:    rdata_nxt = {16'h0000, mask_r};
      ofs_pkg::OFS_GROUP:   rdata_nxt = {27'h000_0000, group_r};
      ofs_pkg::OFS_PATH:    rdata_nxt = {28'h000_0000, path_r};
      ofs_pkg::OFS_START:   rdata_nxt = {24'h00_0000, start_r};
      ofs_pkg::OFS_OUTDATA: rdata_nxt = {16'h0000, out_sw_r};
      ofs_pkg::OFS_REPORT:  rdata_nxt = {16'h0000, out_drive_r};
      ofs_pkg::OFS_VARIANT: rdata_nxt = variant_full ?
                                        ofs_pkg::CAP_FULL : ofs_pkg::CAP_REDUCED; // RULE_11
      default:              rdata_nxt = ofs_pkg::ZERO32;
    endcase
  end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_r <= ofs_pkg::ZERO32;
      irq_r   <= 1'b0;
      alarm_r <= 1'b0;
    end else begin
      rdata_r <= reg_rd ? rdata_nxt : ofs_pkg::ZERO32;
      irq_r   <= |(status_nxt & mask_r);
      alarm_r <= 1'b0; // RULE_02
    end
  end
  assign reg_rdata    = rdata_r;
  assign out_drive    = out_drive_r;
  assign report_valid = rpt_valid_r;
  assign report_group = rpt_group_r;
  assign report_path  = rpt_path_r;
  assign report_addr  = rpt_addr_r;
  assign report_data  = rpt_data_r;
  assign report_info  = rpt_info_r;
  assign irq          = irq_r;
  // A trip is a local condition only; the unit alarm is never raised by it.
  assign unit_alarm   = alarm_r; // RULE_02
  // ==========================================================================
  // Checks
  property p_trip_off;
    @(posedge core_clk) disable iff (!rstn)
    fault_nxt[0] |=> !out_drive[0];
  endproperty
  a_trip_off: assert property (p_trip_off) else $error("tripped output driven"); // RULE_01
  property p_no_alarm;
    @(posedge core_clk) disable iff (!rstn)
    (|fault_r) |-> !unit_alarm;
  endproperty
  a_no_alarm: assert property (p_no_alarm) else $error("unit alarm on trip"); // RULE_02
  property p_report;
    @(posedge core_clk) disable iff (!rstn)
    $rose(fault_nxt[3]) |=> report_valid && report_data[3] && !report_info;
  endproperty
  a_report: assert property (p_report) else $error("trip not reported"); // RULE_03
  property p_bit;
    @(posedge core_clk) disable iff (!rstn)
    fault_nxt[9] |=> fault_r[9];
  endproperty
  a_bit: assert property (p_bit) else $error("fault bit not following"); // RULE_04
  property p_index;
    @(posedge core_clk) disable iff (!rstn)
    report_valid |-> report_addr == $past(start_r) + {7'h00, report_info};
  endproperty
  a_index: assert property (p_index) else $error("report address wrong"); // RULE_05
  property p_group;
    @(posedge core_clk) disable iff (!rstn)
    report_valid |-> report_group == $past(group_r);
  endproperty
  a_group: assert property (p_group) else $error("report group wrong"); // RULE_06
  property p_range;
    @(posedge core_clk) disable iff (!rstn)
    group_r <= ofs_pkg::GROUP_MAX;
  endproperty
  a_range: assert property (p_range) else $error("group out of range"); // RULE_07
  property p_clear;
    @(posedge core_clk) disable iff (!rstn)
    !fault_nxt[5] ##1 !fault_nxt[5] |-> !fault_r[5];
  endproperty
  a_clear: assert property (p_clear) else $error("fault bit stuck"); // RULE_13
  // ==========================================================================
  // Checks on drive, status, report and read paths
  property p_trip_hi;
    @(posedge core_clk) disable iff (!rstn)
    fault_nxt[15] |=> !out_drive[15];
  endproperty
  a_trip_hi: assert property (p_trip_hi) else $error("tripped high output driven"); // RULE_01
  property p_drive_follow;
    @(posedge core_clk) disable iff (!rstn)
    !fault_nxt[7] |=> out_drive[7] == $past(out_sw_r[7]);
  endproperty
  a_drive_follow: assert property (p_drive_follow) else $error("healthy output wrong"); // RULE_01
  property p_fault_copy;
    @(posedge core_clk) disable iff (!rstn)
    1'b1 |=> fault_r == $past(fault_nxt);
  endproperty
  a_fault_copy: assert property (p_fault_copy) else $error("fault bits not live"); // RULE_13
  property p_status_set;
    @(posedge core_clk) disable iff (!rstn)
    rise[2] |=> status_r[2];
  endproperty
  a_status_set: assert property (p_status_set) else $error("status not set"); // RULE_03
  property p_status_keep;
    @(posedge core_clk) disable iff (!rstn)
    1'b1 |=> (status_r & $past(status_keep)) == $past(status_keep);
  endproperty
  a_status_keep: assert property (p_status_keep) else $error("status lost"); // RULE_03
  property p_irq_level;
    @(posedge core_clk) disable iff (!rstn)
    1'b1 |=> irq == |(status_r & $past(mask_r));
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong"); // RULE_03
  property p_quiet;
    @(posedge core_clk) disable iff (!rstn)
    !chg_lo && !chg_hi |=> !report_valid;
  endproperty
  a_quiet: assert property (p_quiet) else $error("report without change"); // RULE_03
  property p_report_lo;
    @(posedge core_clk) disable iff (!rstn)
    chg_lo |=> report_valid && !report_info && report_data == fault_r[7:0];
  endproperty
  a_report_lo: assert property (p_report_lo) else $error("low byte report wrong"); // RULE_04
  property p_report_hi;
    @(posedge core_clk) disable iff (!rstn)
    chg_hi && !chg_lo |=> report_valid && report_info && report_data == fault_r[15:8];
  endproperty
  a_report_hi: assert property (p_report_hi) else $error("high byte report wrong"); // RULE_05
  property p_seen_hi;
    @(posedge core_clk) disable iff (!rstn)
    chg_hi && !chg_lo |=> rpt_seen_hi_r == report_data;
  endproperty
  a_seen_hi: assert property (p_seen_hi) else $error("high byte record wrong"); // RULE_05
  property p_path;
    @(posedge core_clk) disable iff (!rstn)
    report_valid |-> report_path == $past(path_r);
  endproperty
  a_path: assert property (p_path) else $error("report path wrong"); // RULE_06
  property p_group_sat;
    @(posedge core_clk) disable iff (!rstn)
    reg_wr && reg_addr == ofs_pkg::OFS_GROUP && reg_wdata[4:0] > ofs_pkg::GROUP_MAX |=>
    group_r == ofs_pkg::GROUP_MAX;
  endproperty
  a_group_sat: assert property (p_group_sat) else $error("group not saturated"); // RULE_07
  property p_read_fault0;
    @(posedge core_clk) disable iff (!rstn)
    reg_rd && reg_addr == ofs_pkg::OFS_FAULT0 |=> reg_rdata[7:0] == $past(fault_r[7:0]);
  endproperty
  a_read_fault0: assert property (p_read_fault0) else $error("fault byte 0 read wrong"); // RULE_04
  property p_read_fault1;
    @(posedge core_clk) disable iff (!rstn)
    reg_rd && reg_addr == ofs_pkg::OFS_FAULT1 |=> reg_rdata[7:0] == $past(fault_r[15:8]);
  endproperty
  a_read_fault1: assert property (p_read_fault1) else $error("fault byte 1 read wrong"); // RULE_05
  property p_variant;
    @(posedge core_clk) disable iff (!rstn)
    reg_rd && reg_addr == ofs_pkg::OFS_VARIANT && variant_full |=> reg_rdata == ofs_pkg::CAP_FULL;
  endproperty
  a_variant: assert property (p_variant) else $error("variant word wrong"); // RULE_11
endmodule
`default_nettype wire

// [testbench/ofs_load_model.sv]
// Behavioural model of the output loads that trip the driver protection sense.
`timescale 1ns/1ps
`default_nettype none
module ofs_load_model (
  // Clock
  input  wire logic        core_clk,
  // Fault requests from the bench
  input  wire logic [15:0] short_req,
  input  wire logic [15:0] heat_req,
  // Protection sense towards the block
  output var  logic [15:0] drv_overcur,
  output var  logic [15:0] drv_overtemp
);
  // ==========================================================================
  // Sense
  // A real sensor never reacts in zero time, so the sense lags one clock.
  always @(posedge core_clk) begin
    drv_overcur <= short_req;
    drv_overtemp <= heat_req;
  end
endmodule
`default_nettype wire

// [testbench/ofs_tb_top.sv]
// Self-checking bench for the output fault status report block.
`timescale 1ns/1ps
`default_nettype none
module ofs_tb_top;
  // ==========================================================================
  // Stimulus, state and observed outputs
  logic        core_clk = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        variant_full = 1'b0;
  logic [15:0] short_req = 16'h0000;
  logic [15:0] heat_req = 16'h0000;
  logic [31:0] seed = 32'h6890_857c;
  logic [31:0] rd_q[$];
  logic [31:0] rep_q[$];
  logic        rd_seen = 1'b0;
  logic [31:0] f, sw, pth, st;
  int          failures = 0;
  int          n_checks = 0;
  wire logic [31:0] reg_rdata;
  wire logic [15:0] drv_overcur, drv_overtemp, out_drive;
  wire logic        report_valid, report_info, irq, unit_alarm;
  wire logic [4:0]  report_group;
  wire logic [3:0]  report_path;
  wire logic [7:0]  report_addr, report_data;
  wire logic [31:0] rep_seen = {6'h00, report_group, report_path, report_addr,
                                report_data, report_info};
  always #5 core_clk = ~core_clk;
  ofs_top i_ofs_top (.core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .drv_overcur(drv_overcur), .drv_overtemp(drv_overtemp), .variant_full(variant_full),
    .out_drive(out_drive), .report_valid(report_valid), .report_group(report_group),
    .report_path(report_path), .report_addr(report_addr), .report_data(report_data),
    .report_info(report_info), .irq(irq), .unit_alarm(unit_alarm));
  ofs_load_model i_ofs_load_model (.core_clk(core_clk), .short_req(short_req),
    .heat_req(heat_req), .drv_overcur(drv_overcur), .drv_overtemp(drv_overtemp));
  // ==========================================================================
  // Checking helpers
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [31:0] rep(input logic [7:0] a, input logic [7:0] d, input logic i);
    return {6'h00, ofs_pkg::GROUP_MAX, pth[3:0], a, d, i};
  endfunction
  task automatic end_of_test();
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic pop(ref logic [31:0] q[$], input logic [31:0] seen);
    if (q.size() == 0) chk(seen, 32'hffff_ffff);
    else chk(seen, q.pop_front());
  endtask
  // Results are sampled mid-cycle, well clear of the launching edge.
  always @(posedge core_clk) rd_seen <= reg_rd;
  always @(negedge core_clk) begin
    if (rd_seen) pop(rd_q, reg_rdata);
    if (report_valid === 1'b1) pop(rep_q, rep_seen);
  end
  // ==========================================================================
  // Bus and fault tasks
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
  endtask
  task automatic settle();
    int i;
    for (i = 0; i < 40 && rd_q.size() + rep_q.size() != 0; i++) @(posedge core_clk);
    if (rd_q.size() + rep_q.size() != 0) begin
      failures++;
      end_of_test();
    end
  endtask
  task automatic fault(input logic [15:0] nf, input logic [15:0] split);
    rep_q.push_back(rep(st[7:0], nf[7:0], 1'b0));
    rep_q.push_back(rep(8'(st[7:0] + 8'h01), nf[15:8], 1'b1));
    @(posedge core_clk);
    short_req <= nf & split;
    heat_req <= nf & ~split;
    settle();
  endtask
  // ==========================================================================
  // Main sequence
  initial begin
    repeat (10) @(posedge core_clk);
    rstn <= 1'b1;
    rd(ofs_pkg::OFS_STATUS, 32'h0000_0000);
    for (int v = 0; v < 2; v++) begin
      variant_full <= v[0];
      rd(ofs_pkg::OFS_VARIANT, v[0] ? 32'h0318_1004 : 32'h0115_1003);
    end
    wr(ofs_pkg::OFS_GROUP, 32'h0000_001e);
    rd(ofs_pkg::OFS_GROUP, 32'h0000_0017);
    pth = xs() & 32'h0000_000f;
    st = xs() & 32'h0000_00ff;
    sw = xs() & 32'h0000_ffff;
    wr(ofs_pkg::OFS_PATH, pth);
    wr(ofs_pkg::OFS_START, st);
    wr(ofs_pkg::OFS_OUTDATA, sw);
    wr(8'h30, 32'hffff_ffff);
    rd(8'h30, 32'h0000_0000);
    rd(ofs_pkg::OFS_PATH, pth);
    f = (xs() | 32'h0000_0101) & 32'h0000_ffff;
    fault(f[15:0], seed[15:0]);
    rd(ofs_pkg::OFS_FAULT0, f & 32'h0000_00ff);
    rd(ofs_pkg::OFS_FAULT1, f >> 8);
    rd(ofs_pkg::OFS_REPORT, sw & ~f & 32'h0000_ffff);
    @(negedge core_clk);
    chk({16'h0000, out_drive}, sw & ~f & 32'h0000_ffff);
    rd(ofs_pkg::OFS_STATUS, f);
    settle();
    @(negedge core_clk);
    chk({31'h0, irq}, 32'h0000_0000);
    wr(ofs_pkg::OFS_MASK, f & 32'h0000_00ff);
    rd(ofs_pkg::OFS_MASK, f & 32'h0000_00ff);
    settle();
    @(negedge core_clk);
    chk({31'h0, irq}, 32'h0000_0001);
    fault(16'h0000, 16'h0000);
    rd(ofs_pkg::OFS_FAULT0, 32'h0000_0000);
    rd(ofs_pkg::OFS_STATUS, f);
    rd(ofs_pkg::OFS_REPORT, sw);
    @(negedge core_clk);
    chk({16'h0000, out_drive}, sw);
    wr(ofs_pkg::OFS_STATUS, f);
    rd(ofs_pkg::OFS_STATUS, 32'h0000_0000);
    settle();
    @(negedge core_clk);
    chk({31'h0, irq}, 32'h0000_0000);
    chk({31'h0, unit_alarm}, 32'h0000_0000);
    end_of_test();
  end
endmodule
`default_nettype wire
